// file: rtl/partition_feature_id_defines.vh
`ifndef PARTITION_FEATURE_ID_DEFINES_VH
`define PARTITION_FEATURE_ID_DEFINES_VH

// ==========================================
// Register offsets within a feature page
`define CUSTOM_FEATURE_ID_OFFSET    12'h028
`define BANDWIDTH_FEATURE_ID_OFFSET 12'h040
`define PAGE_ADDR_WIDTH             12

// ==========================================
// Page selector codes
`define PAGE_SECURE     2'h0
`define PAGE_NONSECURE  2'h1
`define PAGE_ROOT       2'h2
`define PAGE_REALM      2'h3

// ==========================================
// Bandwidth register field positions
`define BW_PBM_WD_LSB      16
`define BW_PBM_WD_MSB      28
`define BW_WINDOW_WRITABLE_BIT      14
`define BW_PROP_BIT        13
`define BW_PBM_BIT         12
`define BW_MAX_BIT         11
`define BW_MIN_BIT         10
`define BW_ALLOC_WD_MSB    5
`define BW_RESERVED_MASK   32'hE000_83C0

// ==========================================
// Read data when absent
`define ID_READS_ZERO      32'h0000_0000

`endif

// file: rtl/instance_select.v
`timescale 1ns/100ps
`default_nettype none
`include "partition_feature_id_defines.vh"

// ==========================================
// Picks one resource instance out of a flattened table
module instance_select #(
	parameter NUM_INST  = 4,
	parameter SEL_WIDTH = 2
) (
	input  wire [NUM_INST*32-1:0] table_flat,
	input  wire [SEL_WIDTH-1:0]   sel,
	input  wire                   ris_enable,
	output reg  [31:0]            word
);

	integer i;

	always @* begin
		word = table_flat[31:0];
		// Out-of-range selections fall back to instance 0
		if (ris_enable) begin
			for (i = 0; i < NUM_INST; i = i + 1) begin
				if (sel == i[SEL_WIDTH-1:0])
					word = table_flat[i*32 +: 32];
			end
		end
	end

endmodule
`default_nettype wire

// file: rtl/bandwidth_word_build.v
`timescale 1ns/100ps
`default_nettype none
`include "partition_feature_id_defines.vh"

// ==========================================
// Packs bandwidth capability fields, forcing reserved bits low
module bandwidth_word_build (
	input  wire [12:0] portion_bitmap_width,
	input  wire        window_writable,
	input  wire        stride_ctl_present,
	input  wire        portion_ctl_present,
	input  wire        ceiling_present,
	input  wire        floor_present,
	input  wire [5:0]  allocation_field_width,
	output wire [31:0] word
);

	wire [31:0] raw;

	assign raw = {3'h0,
		portion_bitmap_width,
		1'b0,
		window_writable,
		stride_ctl_present,
		portion_ctl_present,
		ceiling_present,
		floor_present,
		4'h0,
		allocation_field_width};
	assign word = raw & ~`BW_RESERVED_MASK;

endmodule
`default_nettype wire

// file: rtl/partition_feature_id_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "partition_feature_id_defines.vh"

module partition_feature_id_regs #(
	parameter NUM_INST  = 4,
	parameter SEL_WIDTH = 2,
	// Per page (4) and per instance tables; page p instance i is entry p*NUM_INST+i, in CUSTOM_TABLE at [(p*NUM_INST+i)*32 +: 32]
	parameter [4*NUM_INST*32-1:0] CUSTOM_TABLE = {4*NUM_INST{32'h0000_0000}},
	parameter [4*NUM_INST*13-1:0] PBM_WD_TABLE = {4*NUM_INST{13'h0020}},
	parameter [4*NUM_INST-1:0]    WINDOW_WRITABLE_TABLE = {4*NUM_INST{1'b0}},
	parameter [4*NUM_INST-1:0]    PROP_TABLE   = {4*NUM_INST{1'b1}},
	parameter [4*NUM_INST-1:0]    PBM_TABLE    = {4*NUM_INST{1'b1}},
	parameter [4*NUM_INST-1:0]    MAX_TABLE    = {4*NUM_INST{1'b1}},
	parameter [4*NUM_INST-1:0]    MIN_TABLE    = {4*NUM_INST{1'b1}},
	parameter [4*NUM_INST*6-1:0]  ALLOCATION_FIELD_WIDTH_TABLE = {4*NUM_INST{6'h10}}
) (
	input  wire                        clk_sys,
	input  wire                        rst_n,
	input  wire                        partitioning_feature,
	input  wire                        realm_management_feature,
	input  wire                        custom_id_present,
	input  wire                        bandwidth_part_present,
	input  wire                        instance_select_supported,
	input  wire [SEL_WIDTH-1:0]        selected_resource_instance,
	input  wire                        req_valid,
	input  wire                        req_write,
	input  wire [1:0]                  req_page,
	input  wire [`PAGE_ADDR_WIDTH-1:0] req_addr,
	input  wire [31:0]                 req_wdata,
	output wire                        req_ready,
	output reg                         rsp_valid,
	output reg  [31:0]                 rsp_rdata
);

	// ==========================================
	// Per page decode of constant tables
	wire [4*32-1:0] custom_page_word;
	wire [4*32-1:0] bw_page_word;

	genvar p, k;
	generate
		for (p = 0; p < 4; p = p + 1) begin : g_page
			wire [NUM_INST*32-1:0] bw_flat;
			for (k = 0; k < NUM_INST; k = k + 1) begin : g_inst
				bandwidth_word_build u_build (
					.portion_bitmap_width   (PBM_WD_TABLE[(p*NUM_INST+k)*13 +: 13]),
					.window_writable        (WINDOW_WRITABLE_TABLE[p*NUM_INST+k]),
					.stride_ctl_present     (PROP_TABLE[p*NUM_INST+k]),
					.portion_ctl_present    (PBM_TABLE[p*NUM_INST+k]),
					.ceiling_present        (MAX_TABLE[p*NUM_INST+k]),
					.floor_present          (MIN_TABLE[p*NUM_INST+k]),
					.allocation_field_width (ALLOCATION_FIELD_WIDTH_TABLE[(p*NUM_INST+k)*6 +: 6]),
					.word                   (bw_flat[k*32 +: 32])
				);
			end
			// Separate copy for every page
			instance_select #(.NUM_INST(NUM_INST), .SEL_WIDTH(SEL_WIDTH)) u_custom_sel (
				.table_flat (CUSTOM_TABLE[p*NUM_INST*32 +: NUM_INST*32]),
				.sel        (selected_resource_instance),
				.ris_enable (instance_select_supported),
				.word       (custom_page_word[p*32 +: 32])
			);
			instance_select #(.NUM_INST(NUM_INST), .SEL_WIDTH(SEL_WIDTH)) u_bw_sel (
				.table_flat (bw_flat),
				.sel        (selected_resource_instance),
				.ris_enable (instance_select_supported),
				.word       (bw_page_word[p*32 +: 32])
			);
		end
	endgenerate

	// ==========================================
	// Read mux; writes are accepted and dropped
	reg  [31:0] read_word;
	wire        page_open;
	wire        unused_wdata;

	// Root and Realm pages only exist with realm management
	assign page_open = (req_page == `PAGE_SECURE) || (req_page == `PAGE_NONSECURE) ||
		realm_management_feature;
	assign unused_wdata = ^req_wdata;
	assign req_ready = 1'b1;

	always @* begin
		read_word = `ID_READS_ZERO;
		case (req_addr)
			`CUSTOM_FEATURE_ID_OFFSET: begin
				if (partitioning_feature && custom_id_present)
					read_word = custom_page_word[req_page*32 +: 32];
			end
			`BANDWIDTH_FEATURE_ID_OFFSET: begin
				if (partitioning_feature && bandwidth_part_present)
					read_word = bw_page_word[req_page*32 +: 32];
			end
			default: read_word = `ID_READS_ZERO;
		endcase
		if (!page_open)
			read_word = `ID_READS_ZERO;
	end

	// ==========================================
	// Answer one cycle after the request; no state beyond it
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= `ID_READS_ZERO;
		end else begin
			rsp_valid <= req_valid;
			if (req_valid && !req_write)
				rsp_rdata <= read_word;
			else if (req_valid)
				rsp_rdata <= `ID_READS_ZERO;
		end
	end

endmodule
`default_nettype wire

// file: verification/partition_feature_id_regs_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "partition_feature_id_defines.vh"
module partition_feature_id_regs_sva (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        partitioning_feature,
	input wire logic        custom_id_present,
	input wire logic        bandwidth_part_present,
	input wire logic        req_valid,
	input wire logic        req_write,
	input wire logic [11:0] req_addr,
	input wire logic        req_ready,
	input wire logic        rsp_valid,
	input wire logic [31:0] rsp_rdata
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// ==========================================
	// Handshake
	ready_high_a: assert property (req_ready) else $error("ready low");
	resp_next_a: assert property (req_valid |=> rsp_valid) else $error("no answer");
	resp_pulse_a: assert property (!req_valid |=> !rsp_valid) else $error("stray answer");
	data_hold_a: assert property (!req_valid |=> $stable(rsp_rdata))
		else $error("data moved");
	// ==========================================
	// Read data content
	write_zero_a: assert property (req_valid && req_write |=> rsp_rdata == 0)
		else $error("write data");
	reserved_low_a: assert property (req_valid && req_addr == 12'h040 |=>
		(rsp_rdata & 32'hE000_83C0) == 0) else $error("reserved set");
	feat_off_a: assert property (req_valid && !partitioning_feature |=> rsp_rdata == 0)
		else $error("feature off");
	custom_off_a: assert property (req_valid && req_addr == 12'h028 &&
		!custom_id_present |=> rsp_rdata == 0) else $error("custom absent");
	bw_off_a: assert property (req_valid && req_addr == 12'h040 &&
		!bandwidth_part_present |=> rsp_rdata == 0) else $error("bw absent");
	alloc_range_a: assert property (req_valid && req_addr == 12'h040 |=>
		rsp_rdata[5:0] <= 6'h10) else $error("alloc width");
endmodule
bind partition_feature_id_regs partition_feature_id_regs_sva u_sva (.clk_sys(clk_sys),
	.rst_n(rst_n), .partitioning_feature(partitioning_feature), .req_valid(req_valid),
	.custom_id_present(custom_id_present), .bandwidth_part_present(bandwidth_part_present),
	.req_write(req_write), .req_addr(req_addr), .req_ready(req_ready),
	.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
`default_nettype wire

// file: verification/test_partition_feature_id_regs.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) check_val(g, e)
module test_partition_feature_id_regs;
	localparam logic [15:0] WIN = 16'h00F0, PROP = 16'hAAAA, MAXT = 16'h5555, MINT = 16'hFF00;
	// One instance without portion control (page 3 instance 3); its width field still reads back as 13'h1000
	localparam logic [15:0] PBMT = 16'h7FFF;
	logic clk_sys, rst_n, part_f, realm_f, cust_p, bw_p, ris_f, req_valid, req_write, req_ready;
	logic rsp_valid;
	logic [1:0] sel, req_page;
	logic [11:0] req_addr;
	logic [31:0] req_wdata, rsp_rdata, d;
	int n_mismatch = 0, checks_done = 0, p, i;
	function automatic logic [31:0] cv(int p, int i);
		return 32'hA500_0000 | (p << 8) | i;
	endfunction
	function automatic logic [511:0] mk_tab();
		logic [511:0] t;
		for (int k = 0; k < 16; k++) t[k*32 +: 32] = cv(k / 4, k % 4);
		return t;
	endfunction
	function automatic logic [31:0] bw(int p, int i);
		int k;
		k = p * 4 + i;
		return {3'h0, 13'h1000, 1'b0, WIN[k], PROP[k], PBMT[k], MAXT[k], MINT[k], 4'h0, 6'h10};
	endfunction
	partition_feature_id_regs #(.NUM_INST(4), .SEL_WIDTH(2), .CUSTOM_TABLE(mk_tab()),
		.PBM_WD_TABLE({16{13'h1000}}), .WINDOW_WRITABLE_TABLE(WIN), .PROP_TABLE(PROP),
		.PBM_TABLE(PBMT), .MAX_TABLE(MAXT), .MIN_TABLE(MINT)) u_partition_feature_id_regs (
		.clk_sys(clk_sys), .rst_n(rst_n), .partitioning_feature(part_f),
		.realm_management_feature(realm_f), .custom_id_present(cust_p),
		.bandwidth_part_present(bw_p), .instance_select_supported(ris_f),
		.selected_resource_instance(sel), .req_valid(req_valid), .req_write(req_write),
		.req_page(req_page), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
	task automatic check_val(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// ==========================================
	// One access, request held for exactly one taking edge
	task automatic acc(input logic w, input logic [1:0] pg, input logic [11:0] a);
		@(negedge clk_sys);
		req_valid = 1'b1;
		req_write = w;
		req_page = pg;
		req_addr = a;
		`CHK({31'h0, req_ready}, 32'h1);
		@(negedge clk_sys);
		req_valid = 1'b0;
		`CHK({31'h0, rsp_valid}, 32'h1);
		d = rsp_rdata;
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		clk_sys = 0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (2000) @(posedge clk_sys);
		n_mismatch++;
		conclude();
	end
	initial begin
		{rst_n, req_valid, req_write, sel, req_page, req_addr} = '0;
		{part_f, realm_f, cust_p, bw_p, ris_f} = 5'h1F;
		req_wdata = 32'hFFFF_FFFF;
		repeat (12) @(negedge clk_sys);
		rst_n = 1'b1;
		for (p = 0; p < 4; p++) for (i = 0; i < 4; i++) begin
			sel = 2'(i);
			acc(1'b0, 2'(p), 12'h028);
			`CHK(d, cv(p, i));
			acc(1'b0, 2'(p), 12'h040);
			`CHK(d, bw(p, i));
			if (d[12]) `CHK(d[28:16], 13'h1000);
		end
		$display("test done: page and instance sweep");
		acc(1'b1, 2'h3, 12'h028);
		`CHK(d, 32'h0);
		acc(1'b0, 2'h3, 12'h028);
		`CHK(d, cv(3, 3));
		acc(1'b1, 2'h0, 12'h040);
		acc(1'b0, 2'h0, 12'h040);
		`CHK(d, bw(0, 3));
		$display("test done: writes ignored");
		ris_f = 1'b0;
		acc(1'b0, 2'h1, 12'h028);
		`CHK(d, cv(1, 0));
		acc(1'b0, 2'h1, 12'h040);
		`CHK(d, bw(1, 0));
		$display("test done: selection off");
		realm_f = 1'b0;
		acc(1'b0, 2'h2, 12'h040);
		`CHK(d, 32'h0);
		acc(1'b0, 2'h0, 12'h044);
		`CHK(d, 32'h0);
		cust_p = 1'b0;
		acc(1'b0, 2'h0, 12'h028);
		`CHK(d, 32'h0);
		acc(1'b0, 2'h0, 12'h040);
		`CHK(d, bw(0, 0));
		{cust_p, bw_p} = 2'b10;
		acc(1'b0, 2'h0, 12'h040);
		`CHK(d, 32'h0);
		{part_f, bw_p} = 2'b01;
		acc(1'b0, 2'h0, 12'h028);
		`CHK(d, 32'h0);
		$display("test done: absent registers");
		// Mid-run reset must clear a nonzero answer
		part_f = 1'b1;
		acc(1'b0, 2'h0, 12'h028);
		`CHK(d, cv(0, 0));
		rst_n = 1'b0;
		@(negedge clk_sys);
		`CHK({31'h0, rsp_valid}, 32'h0);
		`CHK(rsp_rdata, 32'h0);
		rst_n = 1'b1;
		$display("test done: reset clears answer");
		conclude();
	end
endmodule
`default_nettype wire
